// [bench/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// host side of the response stream, consumes bytes with random stalls
module host_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // response stream
    input wire logic rspValid,
    output logic rspTake
);
    // one take per byte, never in the cycle right after a take
    always @(posedge clock) begin
        rspTake <= rst_n && rspValid && !rspTake && ($urandom % 3 == 0);
    end
endmodule // host_model
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rf_cfg_pkg::*;
    logic clock, rst_n, regWr, regRd, cmdValid, cmdLast, rspTake, txFieldUp;
    logic rspValid, fieldOn, collAvoidOff, activeMode, exceptionPulse, rdPend;
    logic irqPin, spareOutA, spareOutB, generalOutPin;
    logic [7:0] regAddr, cmdByte, rspByte;
    logic [31:0] regWdata, regRdata, d;
    logic [3:0] nrm; // normal pin functions
    probe_sigs_t probeSigs;
    int n_fail, checked, nExc;
    logic [31:0] rq[$]; // expected register reads
    logic [7:0] bq[$]; // expected response bytes
    logic [7:0] ids[4] = '{8'h00, 8'h1c, 8'h80, 8'h9c};
    logic [7:0] bad[4] = '{8'h1d, 8'h7f, 8'h9d, 8'hff};
    rf_cfg_field_debug_cmds dut (.ce(1'b1), .irqNormal(nrm[0]),
        .spareANormal(nrm[1]), .spareBNormal(nrm[2]), .gpoNormal(nrm[3]), .*);
    host_model hm (.*);
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input string s, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    // watcher: pops the oldest note whenever a result appears
    always @(posedge clock) begin
        rdPend <= regRd;
        if (rdPend) chk("regRdata", rq.pop_front(), regRdata);
        if (rspTake && rspValid)
            chk("rspByte", bq.size() ? bq.pop_front() : 32'hdead, rspByte);
        if (exceptionPulse) nExc++;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        @(posedge clock);
    endtask
    // sends n bytes, low byte first, then waits for the answer to drain
    task automatic frm(input int n, input logic [47:0] v);
        for (int i = 0; i < n; i++) begin
            cmdByte <= v[8*i+:8];
            cmdValid <= 1'b1;
            cmdLast <= (i == n - 1);
            @(posedge clock);
        end
        cmdValid <= 1'b0;
        for (int k = 0; k < 300 && (bq.size() || rspValid || k < 4); k++)
            @(posedge clock);
    endtask
    task automatic tally_and_finish();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #1000000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {regWr, regRd, cmdValid, cmdLast, txFieldUp} = '0;
        {regAddr, regWdata, cmdByte, nrm, probeSigs} = '0;
        rst_n = 1'b0;
        void'($urandom(32'hbdaa));
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        foreach (ids[i]) begin
            wr(REG_LOAD_SEL, {24'h0, ids[i]});
            wr(REG_LOAD_COUNT, i + 1);
            bq.push_back(8'(i + 1));
            frm(2, {ids[i], OP_SIZE_QUERY});
        end
        wr(REG_LOAD_SEL, 32'h81);
        wr(REG_LOAD_COUNT, 32'h2);
        bq.push_back(8'h2);
        frm(2, {8'h81, OP_SIZE_QUERY});
        for (int e = 0; e < 2; e++) begin
            d = $urandom;
            wr(REG_LOAD_SEL, {8'h0, 8'h40 + e[7:0], 2'h0, e[5:0], 8'h81});
            wr(REG_LOAD_DATA, d);
            bq.push_back(8'h40 + e[7:0]);
            for (int b = 0; b < 4; b++) bq.push_back(d[8*b+:8]);
        end
        frm(2, {8'h81, OP_READBACK});
        foreach (bad[i]) begin
            frm(2, {bad[i], OP_SIZE_QUERY});
            frm(2, {bad[i], OP_READBACK});
        end
        chk("exceptions", 8, nExc);
        wr(REG_STATUS, 32'h1f);
        frm(1, {40'h0, OP_RESERVED});
        rd(REG_STATUS, 32'h0);
        wr(REG_CTRL, 32'h3);
        frm(2, {8'h03, OP_FIELD_ON});
        rd(REG_STATUS, 32'h08);
        txFieldUp <= 1'b1;
        repeat (3) @(posedge clock);
        rd(REG_STATUS, 32'h19);
        chk("fieldOpts", 3'h7, {fieldOn, collAvoidOff, activeMode});
        d = $urandom;
        frm(2, {d[7:0], OP_FIELD_OFF});
        txFieldUp <= 1'b0;
        repeat (3) @(posedge clock);
        rd(REG_STATUS, 32'h03);
        probeSigs <= 51'({$urandom(), $urandom()});
        nrm <= 4'ha;
        frm(6, {8'h43, 8'h2a, 8'h18, 8'h05, GRP_CLOCK, OP_DEBUG_ROUTE});
        @(negedge clock);
        chk("gateOff", nrm, {generalOutPin, spareOutB, spareOutA, irqPin});
        @(posedge clock);
        wr(REG_NV_TESTBUS, 32'h1);
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk("routed", {nrm[3:2], probeSigs.rfClk, probeSigs.clockGrp[5]},
            {generalOutPin, spareOutB, spareOutA, irqPin});
        @(posedge clock);
        frm(3, {8'h31, GRP_TX_ENC, OP_DEBUG_ROUTE});
        @(negedge clock);
        chk("txEnv", {probeSigs.txEncGrp[1], probeSigs.clockGrp[5]},
            {generalOutPin, irqPin});
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire

// [rtl/rf_cfg_field_debug_cmds.sv]
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module rf_cfg_field_debug_cmds
    import rf_cfg_pkg::*;
#(
    parameter int ELEMS = MAX_ELEMS,
    parameter int ROUTES = MAX_ROUTES
) (
    // clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // command byte stream from the host interface
    input wire logic [7:0] cmdByte,
    input wire logic cmdValid,
    input wire logic cmdLast,
    // response byte stream
    output logic [7:0] rspByte,
    output logic rspValid,
    input wire logic rspTake,
    // field control
    output logic fieldOn,
    output logic collAvoidOff,
    output logic activeMode,
    input wire logic txFieldUp,
    output logic exceptionPulse,
    // debug sources and pin functions
    input wire probe_sigs_t probeSigs,
    input wire logic irqNormal,
    input wire logic spareANormal,
    input wire logic spareBNormal,
    input wire logic gpoNormal,
    output logic irqPin,
    output logic spareOutA,
    output logic spareOutB,
    output logic generalOutPin
);

    // -------------------------------------------------------------------
    // elaboration checks
    // -------------------------------------------------------------------
    if (ELEMS < 1 || ELEMS > 63) begin : g_bad_elems
        $error("ELEMS must be 1..63");
    end
    if (ROUTES != MAX_ROUTES) begin : g_bad_routes
        $error("ROUTES must equal the four debug pins");
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    cmd_state_t state_r;             // parser state
    logic [7:0] op_r;                // current command code
    logic [5:0] rbId_r;              // store index under readback
    logic [5:0] rbElem_r;            // element being sent
    logic [2:0] rbByte_r;            // byte within element
    logic [2:0] routeCnt_r;          // route bytes taken so far
    logic [7:0] group_r;             // latched signal group
    route_t routes_r [ROUTES];       // per-pin routing
    logic [1:0] ctrl_r;              // completion flag enables
    logic nvGate_r;                  // nonvolatile test-bus gate
    logic onDone_r;                  // sticky field-on done
    logic offDone_r;                 // sticky field-off done
    logic excSticky_r;               // sticky exception
    logic onPend_r;                  // waiting for field up
    logic offPend_r;                 // waiting for field down
    logic [23:0] loadSel_r;          // store loader selection
    logic [39:0] cfgMem [CFG_IDS][ELEMS]; // {address, content}
    logic [5:0] cfgCount [CFG_IDS];  // registers per configuration

    // -------------------------------------------------------------------
    // decode of the incoming byte
    // -------------------------------------------------------------------
    wire logic take = ce && cmdValid;
    wire logic opTake = take && (state_r == ST_IDLE);
    wire logic argTake = take && (state_r == ST_ARG);
    wire logic routeTake = take && (state_r == ST_ROUTE);
    // identifier range check shared by query and readback
    wire logic idValid = (cmdByte & ID_BANK_MASK) <= ID_LOW_MAX;
    wire logic [5:0] idIdx = cmdByte[7] ?
        ID_HIGH_BASE_IDX + {1'b0, cmdByte[4:0]} : {1'b0, cmdByte[4:0]};
    wire logic isSize = argTake && (op_r == OP_SIZE_QUERY);
    wire logic isRb = argTake && (op_r == OP_READBACK);
    wire logic badId = (isSize || isRb) && !idValid;
    wire logic isOn = argTake && (op_r == OP_FIELD_ON);
    wire logic isOff = argTake && (op_r == OP_FIELD_OFF);
    wire logic isGroup = argTake && (op_r == OP_DEBUG_ROUTE);
    wire logic [5:0] selCount = cfgCount[idIdx];

    // -------------------------------------------------------------------
    // route byte legality
    // -------------------------------------------------------------------
    wire logic [3:0] rPin = cmdByte[7:4];
    wire logic [3:0] rSel = cmdByte[3:0];
    wire logic grpKnown = group_r == GRP_CLOCK || group_r == GRP_TX_ENC ||
        group_r == GRP_TIMER || group_r == GRP_CARD ||
        group_r == GRP_TRX || group_r == GRP_RX_DATA ||
        group_r == GRP_RX_ERR;
    wire logic txResv = group_r == GRP_TX_ENC && rSel > SIG_TX_LAST;
    wire logic selOk = rSel == SIG_RF_CLOCK ||
        (rSel < SIG_RF_CLOCK && grpKnown && !txResv);
    wire logic routeOk = routeTake && rPin <= PIN_GENERAL && selOk;

    // -------------------------------------------------------------------
    // readback byte selection
    // -------------------------------------------------------------------
    wire logic [39:0] rbWord = cfgMem[rbId_r][rbElem_r];
    wire logic [5:0] rbCount = cfgCount[rbId_r];
    wire logic rbLastByte = rbByte_r == 3'(RB_LAST_BYTE);
    wire logic rbLastElem = rbElem_r + 6'h1 >= rbCount;
    wire logic [5:0] nextElem = rbElem_r + 6'h1;
    wire logic [2:0] nextByte = rbLastByte ? 3'h0 : rbByte_r + 3'h1;
    wire logic [39:0] nextWord = rbLastByte ? cfgMem[rbId_r][nextElem]
                                            : rbWord;
    wire logic [7:0] nextRbByte =
        nextByte == 3'h0 ? nextWord[39:32] : nextWord[8*nextByte-8 +: 8];

    // -------------------------------------------------------------------
    // register port decode
    // -------------------------------------------------------------------
    wire logic wrCtrl = ce && regWr && regAddr == REG_CTRL;
    wire logic wrStat = ce && regWr && regAddr == REG_STATUS;
    wire logic wrSel = ce && regWr && regAddr == REG_LOAD_SEL;
    wire logic wrData = ce && regWr && regAddr == REG_LOAD_DATA;
    wire logic wrCount = ce && regWr && regAddr == REG_LOAD_COUNT;
    wire logic wrNv = ce && regWr && regAddr == REG_NV_TESTBUS;
    wire logic [5:0] ldIdx = loadSel_r[7] ?
        ID_HIGH_BASE_IDX + {1'b0, loadSel_r[4:0]} : {1'b0, loadSel_r[4:0]};
    wire logic [5:0] ldElem = loadSel_r[13:8];
    wire logic [5:0] ldCount = regWdata[5:0] > 6'(ELEMS) ?
        6'(ELEMS) : regWdata[5:0];
    wire logic [31:0] statusWord = {27'h0, txFieldUp, fieldOn,
        excSticky_r, offDone_r, onDone_r};
    wire logic [31:0] rdMux =
        regAddr == REG_CTRL ? {30'h0, ctrl_r} :
        regAddr == REG_STATUS ? statusWord :
        regAddr == REG_LOAD_SEL ? {8'h0, loadSel_r} :
        regAddr == REG_NV_TESTBUS ? {31'h0, nvGate_r} : 32'h0;

    // field event detection
    wire logic onEvent = onPend_r && fieldOn && txFieldUp;
    wire logic offEvent = offPend_r && !fieldOn && !txFieldUp;

    // register read data, one cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            regRdata <= 32'h0;
        end else if (ce) begin
            regRdata <= regRd ? rdMux : 32'h0;
        end
    end

    // control and loader registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RESET;
            nvGate_r <= NV_GATE_RESET;
            loadSel_r <= 24'h0;
        end else begin
            if (wrCtrl) ctrl_r <= regWdata[1:0];
            if (wrNv) nvGate_r <= regWdata[NV_GATE_BIT];
            if (wrSel) loadSel_r <= regWdata[23:0];
        end
    end

    // configuration store, filled over the register port
    always_ff @(posedge clock) begin
        if (wrData && ldElem < 6'(ELEMS)) begin
            cfgMem[ldIdx][ldElem] <= {loadSel_r[23:16], regWdata};
        end
        if (wrCount) cfgCount[ldIdx] <= ldCount;
    end

    // sticky flags: a hardware set wins over a write-one clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            onDone_r <= 1'b0;
            offDone_r <= 1'b0;
            excSticky_r <= 1'b0;
        end else if (ce) begin
            onDone_r <= (onEvent && ctrl_r[CTRL_ON_DONE_EN]) ||
                (onDone_r && !(wrStat && regWdata[ST_ON_DONE]));
            offDone_r <= (offEvent && ctrl_r[CTRL_OFF_DONE_EN]) ||
                (offDone_r && !(wrStat && regWdata[ST_OFF_DONE]));
            excSticky_r <= badId ||
                (excSticky_r && !(wrStat && regWdata[ST_EXCEPTION]));
        end
    end

    // field switch and its option bits
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fieldOn <= 1'b0;
            collAvoidOff <= 1'b0;
            activeMode <= 1'b0;
            onPend_r <= 1'b0;
            offPend_r <= 1'b0;
        end else if (ce) begin
            if (isOn) begin
                fieldOn <= 1'b1;
                collAvoidOff <= cmdByte[0];
                activeMode <= cmdByte[1];
                onPend_r <= 1'b1;
                offPend_r <= 1'b0;
            end else if (isOff) begin
                fieldOn <= 1'b0;
                onPend_r <= 1'b0;
                offPend_r <= 1'b1;
            end else begin
                if (onEvent) onPend_r <= 1'b0;
                if (offEvent) offPend_r <= 1'b0;
            end
        end
    end

    // exception pulse, one cycle per rejected identifier
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            exceptionPulse <= 1'b0;
        end else if (ce) begin
            exceptionPulse <= badId;
        end
    end

    // command parser and response sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            op_r <= 8'h0;
            rbId_r <= 6'h0;
            rbElem_r <= 6'h0;
            rbByte_r <= 3'h0;
            routeCnt_r <= 3'h0;
            group_r <= 8'h0;
            rspByte <= 8'h0;
            rspValid <= 1'b0;
        end else if (ce) begin
            case (state_r)
                // reserved code is dropped: stays idle if last, else drains to the frame end
                ST_IDLE: begin
                    if (opTake) begin
                        op_r <= cmdByte;
                        if (!cmdLast && cmdByte != OP_RESERVED &&
                            cmdByte >= OP_SIZE_QUERY &&
                            cmdByte <= OP_DEBUG_ROUTE) begin
                            state_r <= ST_ARG;
                        end else if (!cmdLast) begin
                            state_r <= ST_DRAIN;
                        end
                    end
                end
                ST_ARG: begin
                    if (argTake) begin
                        state_r <= cmdLast ? ST_IDLE : ST_DRAIN;
                        if (isSize && idValid) begin
                            rspByte <= {2'h0, selCount};
                            rspValid <= 1'b1;
                            state_r <= ST_SIZE_RSP;
                        end
                        if (isRb && idValid && selCount != 6'h0) begin
                            rbId_r <= idIdx;
                            rbElem_r <= 6'h0;
                            rbByte_r <= 3'h0;
                            rspByte <= cfgMem[idIdx][0][39:32];
                            rspValid <= 1'b1;
                            state_r <= ST_RB_SEND;
                        end
                        if (isGroup && !cmdLast) begin
                            group_r <= cmdByte;
                            routeCnt_r <= 3'h0;
                            state_r <= ST_ROUTE;
                        end
                    end
                end
                ST_ROUTE: begin
                    if (routeTake) begin
                        routeCnt_r <= routeCnt_r + 3'h1;
                        if (cmdLast) begin
                            state_r <= ST_IDLE;
                        end else if (routeCnt_r == 3'(ROUTES - 1)) begin
                            state_r <= ST_DRAIN;
                        end
                    end
                end
                ST_SIZE_RSP: begin
                    if (rspTake) begin
                        rspValid <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                ST_RB_SEND: begin
                    if (rspTake) begin
                        if (rbLastByte && rbLastElem) begin
                            rspValid <= 1'b0;
                            state_r <= ST_IDLE;
                        end else begin
                            rspByte <= nextRbByte;
                            rbByte_r <= nextByte;
                            if (rbLastByte) rbElem_r <= nextElem;
                        end
                    end
                end
                // swallow surplus bytes up to the frame end
                ST_DRAIN: begin
                    if (take && cmdLast) state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // routing table, one entry per pin
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int i = 0; i < ROUTES; i++) routes_r[i] <= '0;
        end else if (routeOk) begin
            routes_r[rPin[1:0]] <= '{en: 1'b1, group: group_r, sel: rSel};
        end
    end

    function automatic logic probeOf(route_t r, probe_sigs_t s);
        logic v;
        v = 1'b0;
        if (r.sel == SIG_RF_CLOCK) v = s.rfClk;
        else case (r.group)
            GRP_CLOCK: v = s.clockGrp[r.sel[2:0]];
            GRP_TX_ENC: v = s.txEncGrp[r.sel[0]];
            GRP_TIMER: v = s.timerGrp[r.sel[2:0]];
            GRP_CARD: v = s.cardGrp[r.sel[2:0]];
            GRP_TRX: v = s.trxGrp[r.sel[2:0]];
            GRP_RX_DATA: v = s.rxDataGrp[r.sel[2:0]];
            GRP_RX_ERR: v = s.rxErrGrp[r.sel[2:0]];
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    wire logic useA0 = nvGate_r && routes_r[0].en;
    wire logic useA1 = nvGate_r && routes_r[1].en;
    wire logic useA2 = nvGate_r && routes_r[2].en;
    wire logic useA3 = nvGate_r && routes_r[3].en;

    // registered pin drivers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irqPin <= 1'b0;
            spareOutA <= 1'b0;
            spareOutB <= 1'b0;
            generalOutPin <= 1'b0;
        end else if (ce) begin
            irqPin <= useA0 ? probeOf(routes_r[0], probeSigs) : irqNormal;
            spareOutA <= useA1 ? probeOf(routes_r[1], probeSigs)
                               : spareANormal;
            spareOutB <= useA2 ? probeOf(routes_r[2], probeSigs)
                               : spareBNormal;
            generalOutPin <= useA3 ? probeOf(routes_r[3], probeSigs)
                                   : gpoNormal;
        end
    end

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    sequence s_size_ask;
        isSize && idValid;
    endsequence
    a_size_reply: assert property (s_size_ask |=>
        rspValid && rspByte == {2'h0, $past(selCount)})
        else $error("size reply wrong");
    a_size_range: assert property (isSize && !idValid |=>
        exceptionPulse && !rspValid) else $error("bad id not rejected");
    a_rb_range: assert property (isRb && !idValid |=>
        exceptionPulse && state_r != ST_RB_SEND)
        else $error("readback bad id");
    a_rb_addr_first: assert property (isRb && idValid && selCount != 0
        |=> rspByte == rbWord[39:32] && rbByte_r == 0)
        else $error("readback not address first");
    a_rb_lsb_first: assert property (ce && state_r == ST_RB_SEND &&
        rspTake && rbByte_r == 0 |=> rspByte == rbWord[7:0])
        else $error("content not lsb first");
    a_reserved_op: assert property (opTake && cmdLast &&
        cmdByte == OP_RESERVED |=> state_r == ST_IDLE && !rspValid &&
        $stable(fieldOn))
        else $error("reserved code acted");
    a_field_on: assert property (isOn |=> fieldOn &&
        collAvoidOff == $past(cmdByte[0]) && activeMode == $past(cmdByte[1]))
        else $error("field on wrong");
    a_on_done: assert property ($rose(onDone_r) |->
        $past(fieldOn && txFieldUp)) else $error("on flag early");
    a_field_off: assert property (isOff |=> !fieldOn)
        else $error("field not off");
    a_off_done: assert property ($rose(offDone_r) |->
        $past(!fieldOn && !txFieldUp)) else $error("off flag early");
    a_gate_closed: assert property (ce && !nvGate_r |=>
        irqPin == $past(irqNormal) && spareOutA == $past(spareANormal))
        else $error("debug leaked");
    a_route_resv: assert property (routeTake && !routeOk |=>
        routes_r[0] == $past(routes_r[0]) &&
        routes_r[3] == $past(routes_r[3])) else $error("reserved routed");

endmodule // rf_cfg_field_debug_cmds

`default_nettype wire

// [rtl/rf_cfg_pkg.sv]
package rf_cfg_pkg;

    // -------------------------------------------------------------------
    // command codes
    // -------------------------------------------------------------------
    localparam logic [7:0] OP_SIZE_QUERY = 8'h13;
    localparam logic [7:0] OP_READBACK = 8'h14;
    localparam logic [7:0] OP_RESERVED = 8'h15;
    localparam logic [7:0] OP_FIELD_ON = 8'h16;
    localparam logic [7:0] OP_FIELD_OFF = 8'h17;
    localparam logic [7:0] OP_DEBUG_ROUTE = 8'h18;

    // -------------------------------------------------------------------
    // configuration identifiers and store shape
    // -------------------------------------------------------------------
    localparam logic [7:0] ID_LOW_MAX = 8'h1c;
    localparam logic [7:0] ID_BANK_MASK = 8'h7f;
    localparam logic [5:0] ID_HIGH_BASE_IDX = 6'h1d;
    localparam int CFG_IDS = 58;
    localparam int MAX_ELEMS = 39;
    localparam int MAX_ROUTES = 4;
    localparam int RB_LAST_BYTE = 4;

    // -------------------------------------------------------------------
    // debug routing codes
    // -------------------------------------------------------------------
    localparam logic [7:0] GRP_CLOCK = 8'h01;
    localparam logic [7:0] GRP_TX_ENC = 8'h1b;
    localparam logic [7:0] GRP_TIMER = 8'h1d;
    localparam logic [7:0] GRP_CARD = 8'h30;
    localparam logic [7:0] GRP_TRX = 8'h58;
    localparam logic [7:0] GRP_RX_DATA = 8'h70;
    localparam logic [7:0] GRP_RX_ERR = 8'h73;
    localparam logic [3:0] SIG_RF_CLOCK = 4'h8;
    localparam logic [3:0] SIG_TX_LAST = 4'h1;
    localparam logic [3:0] PIN_IRQ = 4'h0;
    localparam logic [3:0] PIN_SPARE_A = 4'h1;
    localparam logic [3:0] PIN_SPARE_B = 4'h2;
    localparam logic [3:0] PIN_GENERAL = 4'h3;

    // -------------------------------------------------------------------
    // register map (byte addresses) and fields
    // -------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LOAD_SEL = 8'h08;
    localparam logic [7:0] REG_LOAD_DATA = 8'h0c;
    localparam logic [7:0] REG_LOAD_COUNT = 8'h10;
    localparam logic [7:0] REG_NV_TESTBUS = 8'h5c;
    localparam int CTRL_ON_DONE_EN = 0;
    localparam int CTRL_OFF_DONE_EN = 1;
    localparam int ST_ON_DONE = 0;
    localparam int ST_OFF_DONE = 1;
    localparam int ST_EXCEPTION = 2;
    localparam int ST_FIELD_ON = 3;
    localparam int ST_FIELD_UP = 4;
    localparam int NV_GATE_BIT = 0;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic NV_GATE_RESET = 1'b0;

    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] clockGrp;
        logic [1:0] txEncGrp;
        logic [7:0] timerGrp;
        logic [7:0] cardGrp;
        logic [7:0] trxGrp;
        logic [7:0] rxDataGrp;
        logic [7:0] rxErrGrp;
        logic rfClk;
    } probe_sigs_t;

    typedef struct packed {
        logic en;
        logic [7:0] group;
        logic [3:0] sel;
    } route_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ARG, ST_ROUTE, ST_SIZE_RSP, ST_RB_SEND, ST_DRAIN
    } cmd_state_t;

endpackage
